// ### flow_totalizer.v
// Two-input totalizer front end with integrator, trip compare and AHB-Lite registers
// Contract
// - Sum two inputs, integrate into running total
// - Increment is converted sum; period applied in rate conversion only
// - Qualify, then convert, then apply direction
// - Option bits 0/1 pick rate or accumulation
// - Bad/uncertain become good by option bits
// - Bad raw status uses last good value
// - Rate: time base, unit scale on second input only, times period
// - Accumulation: delta times pulse weight, unit scale on second input only
// - Reverse-flow flag negates converted value
// - Keep flow flags, not input values; flow flags here reset to RST_FLOW
// - Sum bad if either qualified input bad
// - Total, forward or reverse addition modes
// - Option bits 2/3 choose addition mode
// - Unconnected input ignored in addition
// - Option bit 7 zeroes bad increment
// - Clear input clears totals; confirm accepted
// - Prelimit and trip outputs from compare
//
// Decided for this implementation: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "totalizer_consts.vh"

module flow_totalizer #(
	parameter integer FRAC = 16
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg         hresp,
	output reg  [31:0] hrdata,
	input  wire [31:0] value_a,
	input  wire [1:0]  status_a,
	input  wire [31:0] value_b,
	input  wire [1:0]  status_b,
	input  wire        exec_tick,
	input  wire        clear_input,
	input  wire        clear_confirm_input,
	output reg  [31:0] incr_out,
	output reg         incr_bad,
	output reg         incr_valid,
	output reg  [31:0] total_out,
	output reg         trip_flag,
	output reg         prelimit_reached_flag,
	output reg         irq
);

	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_QUAL = 5'b00010;
	localparam [4:0] S_CONV = 5'b00100;
	localparam [4:0] S_DIR  = 5'b01000;
	localparam [4:0] S_ADD  = 5'b10000;

	// Fixed-point product, Q(32-FRAC).FRAC
	function signed [31:0] qmul;
		input signed [31:0] a;
		input signed [31:0] b;
		reg signed [63:0] p;
		begin
			p = a * b;
			qmul = p[FRAC+31:FRAC];
		end
	endfunction

	reg         [7:0]  opts_q;
	reg         [4:0]  flow_q;
	reg         [31:0] tbase_a_q;
	reg         [31:0] tbase_b_q;
	reg         [31:0] uscale_q;
	reg         [31:0] pulse_a_q;
	reg         [31:0] pulse_b_q;
	reg         [31:0] period_q;
	reg         [31:0] setpt_q;
	reg         [31:0] prelim_q;
	reg  [`EV_WIDTH-1:0] ev_stat_q;
	reg  [`EV_WIDTH-1:0] ev_mask_q;
	reg  [4:0]         state_q;
	reg  signed [31:0] total_q;
	reg                wr_pend_q;
	reg         [7:0]  wr_addr_q;
	reg                sum_bad_q;

	wire        acc_take = hsel & htrans[1] & hready;
	wire [7:0]  acc_ofs  = haddr[7:0];
	wire        down     = flow_q[`FLW_DOWN];

	// Per-input pipeline, one copy per input
	wire signed [31:0] conv_w [0:1];
	wire               good_w [0:1];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
			wire signed [31:0] raw    = (gi == 0) ? value_a : value_b;
			wire        [1:0]  st     = (gi == 0) ? status_a : status_b;
			wire signed [31:0] tbase  = (gi == 0) ? tbase_a_q : tbase_b_q;
			wire signed [31:0] pulse  = (gi == 0) ? pulse_a_q : pulse_b_q;
			wire               accum  = opts_q[gi];
			wire               rev    = flow_q[`FLW_REV_A + gi];
			wire               conn   = flow_q[`FLW_CONN_A + gi];
			wire               raw_bad = (st == `ST_BAD);
			wire               raw_unc = (st == `ST_UNC);
			reg  signed [31:0] last_q;
			reg  signed [31:0] use_q;
			reg  signed [31:0] prev_q;
			reg  signed [31:0] conv_q;
			reg                good_q;
			reg  signed [31:0] rate_v;
			reg  signed [31:0] acc_v;

			always @* begin
				rate_v = qmul(use_q, tbase);
				acc_v  = qmul(use_q - prev_q, pulse);
				// Second input to first input's unit
				if (gi == 1) begin
					rate_v = qmul(rate_v, uscale_q);
					acc_v = qmul(acc_v, uscale_q);
				end
				rate_v = qmul(rate_v, period_q);
			end

			// Input values are volatile: cleared to zero by reset
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					last_q <= `RST_ZERO;
					use_q  <= `RST_ZERO;
					prev_q <= `RST_ZERO;
					conv_q <= `RST_ZERO;
					good_q <= 1'b0;
				end else begin
					case (state_q)
						S_QUAL: begin
							good_q <= raw_bad ? opts_q[`OPT_USE_BAD] :
								raw_unc ? opts_q[`OPT_USE_UNC] : 1'b1;
							// Hold last good value when raw bad
							use_q <= raw_bad ? last_q : raw;
							if (!raw_bad)
								last_q <= raw;
						end
						S_CONV: begin
							if (accum) begin
								conv_q <= acc_v;
							end else begin
								conv_q <= rate_v;
							end
							prev_q <= use_q;
						end
						S_DIR: begin
							if (rev)
								conv_q <= -conv_q;
						end
						default: begin
							conv_q <= conv_q;
						end
					endcase
				end
			end

			assign conv_w[gi] = conn ? conv_q : `RST_ZERO;
			assign good_w[gi] = conn ? good_q : 1'b1;
		end
	endgenerate

	// Adder
	reg  signed [31:0] part_a;
	reg  signed [31:0] part_b;
	reg  signed [31:0] sum_v;
	reg                sum_bad;
	reg         [1:0]  mode;

	always @* begin
		mode   = {opts_q[`OPT_REV], opts_q[`OPT_FWD]};
		part_a = conv_w[0];
		part_b = conv_w[1];
		// Mode select; both or neither gives total
		case (mode)
			2'b01: begin
				if (part_a[31]) part_a = `RST_ZERO;
				if (part_b[31]) part_b = `RST_ZERO;
			end
			2'b10: begin
				if (!part_a[31]) part_a = `RST_ZERO;
				if (!part_b[31]) part_b = `RST_ZERO;
			end
			default: begin
				part_a = conv_w[0];
			end
		endcase
		// Sum bad when either side bad
		sum_bad = ~(good_w[0] & good_w[1]);
		// Rate-mode converted values already carry the period; accumulation values do not
		sum_v = part_a + part_b;
		if (sum_bad && opts_q[`OPT_ZERO_BAD])
			sum_v = `RST_ZERO;
	end

	// Sequencer
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= S_IDLE;
		end else begin
			// One pass per tick, ticks during a pass dropped
			case (state_q)
				S_IDLE: state_q <= exec_tick ? S_QUAL : S_IDLE;
				S_QUAL: state_q <= S_CONV;
				S_CONV: state_q <= S_DIR;
				S_DIR:  state_q <= S_ADD;
				S_ADD:  state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// Increment register and integrator
	reg  signed [31:0] out_v;
	reg                trip_d;
	reg                pre_d;

	always @* begin
		out_v = down ? ($signed(setpt_q) - total_q) : total_q;
		if (down) begin
			trip_d = (out_v <= $signed(`RST_ZERO));
			pre_d  = (out_v <= $signed(prelim_q));
		end else begin
			trip_d = (out_v >= $signed(setpt_q));
			pre_d  = (out_v >= $signed(setpt_q) - $signed(prelim_q));
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			incr_out   <= `RST_ZERO;
			incr_bad   <= 1'b0;
			incr_valid <= 1'b0;
			sum_bad_q  <= 1'b0;
			total_q    <= `RST_ZERO;
			total_out  <= `RST_ZERO;
			trip_flag  <= 1'b0;
			prelimit_reached_flag <= 1'b0;
		end else begin
			incr_valid <= (state_q == S_ADD);
			if (state_q == S_ADD) begin
				incr_out  <= sum_v;
				incr_bad  <= sum_bad;
				sum_bad_q <= sum_bad;
			end
			if (clear_input) begin
				total_q <= `RST_ZERO;
			end else if (incr_valid) begin
				total_q <= total_q + $signed(incr_out);
			end
			total_out <= out_v;
			trip_flag <= trip_d;
			prelimit_reached_flag <= pre_d;
		end
	end

	// Events: read of status clears, a new set wins
	reg  [`EV_WIDTH-1:0] ev_set;
	wire                 stat_rd = acc_take & ~hwrite & (acc_ofs == `OFS_IRQ_STAT);

	always @* begin
		ev_set = {`EV_WIDTH{1'b0}};
		ev_set[`EV_DONE]    = incr_valid;
		ev_set[`EV_SUM_BAD] = incr_valid & incr_bad;
		ev_set[`EV_PRELIM]  = pre_d & ~prelimit_reached_flag;
		ev_set[`EV_TRIP]    = trip_d & ~trip_flag;
		ev_set[`EV_CONFIRM] = clear_confirm_input;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ev_stat_q <= {`EV_WIDTH{1'b0}};
			irq       <= 1'b0;
		end else begin
			ev_stat_q <= (stat_rd ? {`EV_WIDTH{1'b0}} : ev_stat_q) | ev_set;
			irq       <= |(((stat_rd ? {`EV_WIDTH{1'b0}} : ev_stat_q) | ev_set) & ev_mask_q);
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY
	reg [31:0] rd_d;

	always @* begin
		if (acc_ofs == `OFS_OPTS) begin
			rd_d = {24'h000000, opts_q};
		end else if (acc_ofs == `OFS_FLOW) begin
			rd_d = {27'h0000000, flow_q};
		end else if (acc_ofs == `OFS_TBASE_A) begin
			rd_d = tbase_a_q;
		end else if (acc_ofs == `OFS_TBASE_B) begin
			rd_d = tbase_b_q;
		end else if (acc_ofs == `OFS_USCALE) begin
			rd_d = uscale_q;
		end else if (acc_ofs == `OFS_PULSE_A) begin
			rd_d = pulse_a_q;
		end else if (acc_ofs == `OFS_PULSE_B) begin
			rd_d = pulse_b_q;
		end else if (acc_ofs == `OFS_PERIOD) begin
			rd_d = period_q;
		end else if (acc_ofs == `OFS_SETPT) begin
			rd_d = setpt_q;
		end else if (acc_ofs == `OFS_PRELIM) begin
			rd_d = prelim_q;
		end else if (acc_ofs == `OFS_TOTAL) begin
			rd_d = total_q;
		end else if (acc_ofs == `OFS_OUTV) begin
			rd_d = total_out;
		end else if (acc_ofs == `OFS_INCR) begin
			rd_d = incr_out;
		end else if (acc_ofs == `OFS_SUMST) begin
			rd_d = {28'h0000000, (state_q != S_IDLE), prelimit_reached_flag,
				trip_flag, sum_bad_q};
		end else if (acc_ofs == `OFS_IRQ_STAT) begin
			rd_d = {27'h0000000, ev_stat_q};
		end else if (acc_ofs == `OFS_IRQ_MASK) begin
			rd_d = {27'h0000000, ev_mask_q};
		end else begin
			rd_d = `RST_ZERO;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= `RST_ZERO;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_q <= acc_take & hwrite;
			if (acc_take)
				wr_addr_q <= acc_ofs;
			if (acc_take && !hwrite)
				hrdata <= rd_d;
		end
	end

	// Write data phase; flow flags are not cleared by a clear input
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opts_q    <= `RST_OPTS;
			// Flags reset to RST_FLOW (both inputs connected); software restores after power loss
			flow_q    <= `RST_FLOW;
			tbase_a_q <= `RST_ONE_Q16;
			tbase_b_q <= `RST_ONE_Q16;
			uscale_q  <= `RST_ONE_Q16;
			pulse_a_q <= `RST_ONE_Q16;
			pulse_b_q <= `RST_ONE_Q16;
			period_q  <= `RST_ONE_Q16;
			setpt_q   <= `RST_ZERO;
			prelim_q  <= `RST_ZERO;
			ev_mask_q <= {`EV_WIDTH{1'b0}};
		end else if (wr_pend_q) begin
			if (wr_addr_q == `OFS_OPTS) begin
				opts_q <= hwdata[7:0];
			end else if (wr_addr_q == `OFS_FLOW) begin
				flow_q <= hwdata[4:0];
			end else if (wr_addr_q == `OFS_TBASE_A) begin
				tbase_a_q <= hwdata;
			end else if (wr_addr_q == `OFS_TBASE_B) begin
				tbase_b_q <= hwdata;
			end else if (wr_addr_q == `OFS_USCALE) begin
				uscale_q <= hwdata;
			end else if (wr_addr_q == `OFS_PULSE_A) begin
				pulse_a_q <= hwdata;
			end else if (wr_addr_q == `OFS_PULSE_B) begin
				pulse_b_q <= hwdata;
			end else if (wr_addr_q == `OFS_PERIOD) begin
				period_q <= hwdata;
			end else if (wr_addr_q == `OFS_SETPT) begin
				setpt_q <= hwdata;
			end else if (wr_addr_q == `OFS_PRELIM) begin
				prelim_q <= hwdata;
			end else if (wr_addr_q == `OFS_IRQ_MASK) begin
				ev_mask_q <= hwdata[`EV_WIDTH-1:0];
			end
		end
	end

endmodule
`default_nettype wire

// ### totalizer_consts.vh
// Register offsets, field positions and reset values of the totalizer front end
`ifndef TOTALIZER_CONSTS_VH
`define TOTALIZER_CONSTS_VH

// Register byte offsets (word aligned)
`define OFS_OPTS       8'h00
`define OFS_FLOW       8'h04
`define OFS_TBASE_A    8'h08
`define OFS_TBASE_B    8'h0C
`define OFS_USCALE     8'h10
`define OFS_PULSE_A    8'h14
`define OFS_PULSE_B    8'h18
`define OFS_PERIOD     8'h1C
`define OFS_SETPT      8'h20
`define OFS_PRELIM     8'h24
`define OFS_TOTAL      8'h28
`define OFS_OUTV       8'h2C
`define OFS_INCR       8'h30
`define OFS_SUMST      8'h34
`define OFS_IRQ_STAT   8'h38
`define OFS_IRQ_MASK   8'h3C

// Integration option word bits
`define OPT_ACCUM_A    0
`define OPT_ACCUM_B    1
`define OPT_FWD        2
`define OPT_REV        3
`define OPT_USE_UNC    4
`define OPT_USE_BAD    5
`define OPT_ZERO_BAD   7

// Flow register bits
`define FLW_REV_A      0
`define FLW_REV_B      1
`define FLW_CONN_A     2
`define FLW_CONN_B     3
`define FLW_DOWN       4

// Event bits of status and mask registers
`define EV_DONE        0
`define EV_SUM_BAD     1
`define EV_PRELIM      2
`define EV_TRIP        3
`define EV_CONFIRM     4
`define EV_WIDTH       5

// Input status codes; 2'b11 counts as good
`define ST_BAD         2'b00
`define ST_UNC         2'b01

// Reset values
`define RST_OPTS       8'h00
`define RST_FLOW       5'h0C
`define RST_ONE_Q16    32'h0001_0000
`define RST_ZERO       32'h0000_0000

`endif

// ### upstream_src.sv
// Upstream function-block model that supplies both inputs with status
`timescale 1ns/1ps
`default_nettype none
module upstream_src (
	input  wire logic        hclk,
	output var  logic [31:0] value_a,
	output var  logic [1:0]  status_a,
	output var  logic [31:0] value_b,
	output var  logic [1:0]  status_b
);
	initial begin
		value_a  = 32'h0000_0000;
		status_a = 2'b11;
		value_b  = 32'h0000_0000;
		status_b = 2'b11;
	end

	// New values land just after an edge, as a block writing its output would
	task automatic put(input logic [31:0] va, input logic [1:0] sa, input logic [31:0] vb);
		@(posedge hclk);
		value_a  <= va;
		status_a <= sa;
		value_b  <= vb;
		status_b <= 2'b11;
	endtask
endmodule
`default_nettype wire

// ### tot_chk_asserts.sv
// Port-level checker for the totalizer front end
`timescale 1ns/1ps
`default_nettype none
module tot_chk (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        exec_tick,
	input wire logic        clear_input,
	input wire logic [31:0] incr_out,
	input wire logic        incr_valid,
	input wire logic [31:0] total_out,
	input wire logic        trip_flag,
	input wire logic        prelimit_reached_flag,
	input wire logic        irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	wire logic take    = hsel && htrans[1] && hready;
	wire logic stat_rd = take && !hwrite && haddr[7:0] == 8'h38;
	wire logic mask_wr = take && hwrite && haddr[7:0] == 8'h3C;

	sequence s_pass;
		incr_valid && !clear_input;
	endsequence
	sequence s_clear;
		clear_input [*3];
	endsequence

	a_valid_tick: assert property (incr_valid |-> $past(exec_tick, 5))
		else $error("increment valid without a tick five edges before");
	a_valid_gap: assert property (incr_valid |=> !incr_valid [*4])
		else $error("increments closer than one pass apart");
	a_incr_hold: assert property ($changed(incr_out) |-> incr_valid)
		else $error("increment changed without valid");
	a_total_step: assert property (s_pass |=> ##1 total_out == $past(total_out)
		+ $past(incr_out, 2))
		else $error("total did not advance by the increment");
	a_total_clear: assert property (s_clear |=> total_out == 32'h0000_0000)
		else $error("total not held at zero while clearing");
	a_trip_prelim: assert property (trip_flag |-> prelimit_reached_flag)
		else $error("trip set without prelimit");
	// Status read clears at once; a mask write reaches irq two edges after its address
	a_irq_fall: assert property ($fell(irq) |-> $past(stat_rd) || $past(mask_wr, 3))
		else $error("interrupt dropped without status read or mask write");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or answered with error");
endmodule
`default_nettype wire

bind flow_totalizer tot_chk chk_u (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.exec_tick, .clear_input, .incr_out, .incr_valid, .total_out, .trip_flag,
	.prelimit_reached_flag, .irq
);

// ### tb_top.sv
// Self-checking testbench for the totalizer front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        hclk = 0;
	logic        hresetn = 0;
	logic        hsel = 0;
	logic [31:0] haddr = 0;
	logic [1:0]  htrans = 0;
	logic        hwrite = 0;
	logic [31:0] hwdata = 0;
	logic        exec_tick = 0;
	logic        clear_input = 0;
	logic        clear_confirm_input = 0;
	logic [31:0] r;
	wire  logic  hreadyout, hresp, incr_bad, incr_valid, trip_flag, prelimit_reached_flag, irq;
	wire  logic [31:0] hrdata, incr_out, total_out, value_a, value_b;
	wire  logic [1:0]  status_a, status_b;
	int          checked = 0;
	int          n_mismatch = 0;
	// Rows: flow, options, value a, status a, value b, increment, sum bad
	int          t[14][7] = '{
		'{'h0C, 'h00, 2, 3, 3, 5, 0}, '{'h0D, 'h00, 2, 3, 3, 1, 0},
		'{'h0D, 'h04, 2, 3, 3, 3, 0}, '{'h0D, 'h08, 2, 3, 3, -2, 0},
		'{'h0D, 'h0C, 2, 3, 3, 1, 0}, '{'h0C, 'h00, 4, 0, 3, 5, 1},
		'{'h0C, 'h20, 4, 0, 3, 5, 0}, '{'h0C, 'h80, 4, 0, 3, 0, 1},
		'{'h0C, 'h10, 4, 1, 3, 7, 0}, '{'h0C, 'h00, 4, 1, 3, 7, 1},
		'{'h0C, 'h01, 6, 3, 3, 5, 0}, '{'h0C, 'h03, 6, 3, 5, 2, 0},
		'{'h08, 'h00, 4, 3, 3, 3, 0}, '{'h0C, 'h02, 3, 3, 5, 27, 0}};

	always #12.5 hclk = ~hclk;

	upstream_src src_u (.hclk, .value_a, .status_a, .value_b, .status_b);

	flow_totalizer dut_u (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .value_a, .status_a, .value_b,
		.status_b, .exec_tick, .clear_input, .clear_confirm_input, .incr_out, .incr_bad,
		.incr_valid, .total_out, .trip_flag, .prelimit_reached_flag, .irq
	);

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {24'h00_0000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		chk(r, e);
	endtask

	task automatic run(input int i);
		src_u.put(32'(t[i][2] << 16), 2'(t[i][3]), 32'(t[i][4] << 16));
		@(posedge hclk);
		exec_tick <= 1'b1;
		@(posedge hclk);
		exec_tick <= 1'b0;
		repeat (4) @(posedge hclk);
		@(negedge hclk);
		chk(incr_valid, 32'h1);
		chk(incr_out, 32'(t[i][5] << 16));
		chk(incr_bad, 32'(t[i][6]));
		repeat (2) @(posedge hclk);
	endtask

	task automatic wrap_up();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (4000) @(posedge hclk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rd(8'h00, 32'h0000_0000);
		rd(8'h04, 32'h0000_000C);
		rd(8'h1C, 32'h0001_0000);
		rd(8'h38, 32'h0000_000C);
		xfer(1'b1, 8'h20, 32'h0064_0000);
		xfer(1'b1, 8'h3C, 32'h0000_0001);
		for (int i = 0; i < 13; i++) begin
			xfer(1'b1, 8'h04, t[i][0]);
			xfer(1'b1, 8'h00, t[i][1]);
			run(i);
			if (i == 0) begin
				@(negedge hclk);
				chk(total_out, 32'h0005_0000);
				chk(irq, 32'h1);
				rd(8'h38, 32'h0000_0001);
				@(negedge hclk);
				chk(irq, 32'h0);
			end
		end
		// Non-unity time base, unit scale, pulse weight and period
		xfer(1'b1, 8'h08, 32'h0002_0000);
		xfer(1'b1, 8'h10, 32'h0003_0000);
		xfer(1'b1, 8'h18, 32'h0004_0000);
		xfer(1'b1, 8'h1C, 32'h0000_8000);
		xfer(1'b1, 8'h04, t[13][0]);
		xfer(1'b1, 8'h00, t[13][1]);
		run(13);
		xfer(1'b1, 8'h20, 32'h0001_0000);
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		chk(trip_flag, 32'h1);
		chk(prelimit_reached_flag, 32'h1);
		rd(8'h38, 32'h0000_000F);
		@(posedge hclk);
		clear_input <= 1'b1;
		clear_confirm_input <= 1'b1;
		repeat (4) @(posedge hclk);
		clear_input <= 1'b0;
		clear_confirm_input <= 1'b0;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk(total_out, 32'h0000_0000);
		chk(trip_flag, 32'h0);
		rd(8'h38, 32'h0000_0010);
		xfer(1'b1, 8'h28, 32'hFFFF_FFFF);
		rd(8'h28, 32'h0000_0000);
		xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0000_0000);
		// Counting down: output is setpoint minus total
		xfer(1'b1, 8'h04, 32'h0000_001C);
		xfer(1'b1, 8'h24, 32'h0002_0000);
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk(total_out, 32'h0001_0000);
		chk(prelimit_reached_flag, 32'h1);
		chk(trip_flag, 32'h0);
		rd(8'h04, 32'h0000_001C);
		wrap_up();
	end
endmodule
`default_nettype wire
